// ==== core/css_pkg.sv ====
package css_pkg;

    // ----------------------------------------
    // types
    // ----------------------------------------
    localparam int CNT_W = 17;

    typedef enum logic [2:0] {SRC_XTAL, SRC_LFXTAL, SRC_EXTRC, SRC_INTRC, SRC_EXTCLK} css_src_t;
    typedef enum logic [2:0] {WC_6, WC_18, WC_258, WC_1K, WC_16K, WC_32K} css_wcnt_t;
    typedef enum logic [1:0] {DL_NONE, DL_SHORT, DL_LONG} css_dly_t;
    typedef enum logic [2:0] {MD_ACTIVE, MD_IDLE, MD_NOISE, MD_PWRDN, MD_PWRSAVE, MD_STANDBY} css_mode_t;
    typedef enum logic [2:0] {ST_BOOT, ST_DELAY, ST_START, ST_RUN, ST_SLEEP} css_state_t;

    // ----------------------------------------
    // fuse decoding
    // ----------------------------------------
    localparam logic [3:0] FUSE_XTAL_MIN = 4'hA;
    localparam logic [3:0] FUSE_LFXTAL = 4'h9;
    localparam logic [3:0] FUSE_EXTRC_MIN = 4'h5;
    localparam logic [3:0] FUSE_INTRC_MIN = 4'h1;
    localparam logic [2:0] XTAL_RNG_LOW = 3'h5;
    localparam logic [2:0] XTAL_RNG_MID = 3'h6;
    localparam logic [2:0] XTAL_RNG_HIGH = 3'h7;
    localparam logic [1:0] RNG_LOW = 2'h0;
    localparam logic [1:0] RNG_MID = 2'h1;
    localparam logic [1:0] RNG_HIGH = 2'h2;
    localparam logic [1:0] RNG_WIDE = 2'h3;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [1:0] SUT_RESERVED = 2'h3;

    // shipped fuse state
    localparam logic [3:0] SHIP_SRC = 4'h1;
    localparam logic [1:0] SHIP_SUT = 2'h2;
    localparam logic SHIP_AMP = 1'b1;

    // ----------------------------------------
    // counts, in cycles of the timing source
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CNT_6 = 17'h0_0006;
    localparam logic [CNT_W-1:0] CNT_18 = 17'h0_0012;
    localparam logic [CNT_W-1:0] CNT_258 = 17'h0_0102;
    localparam logic [CNT_W-1:0] CNT_1K = 17'h0_0400;
    localparam logic [CNT_W-1:0] DLY_SHORT = 17'h0_1000;
    localparam logic [CNT_W-1:0] CNT_ONE = 17'h0_0001;

    // async timer rate check
    localparam int MCLK_HZ = 32'h02FA_F080;
    localparam int ASY_HZ = 32'h0000_8000;
    localparam int ASY_RATIO = 32'h0000_0004;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] REG_FUSE = 8'h00;
    localparam logic [7:0] REG_SLEEP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int FUSE_SRC_LSB = 0;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_AMP_BIT = 6;
    localparam int SLP_MODE_LSB = 0;
    localparam int SLP_ASY_BIT = 3;
    localparam int SLP_GO_BIT = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : css_pkg

// ==== core/css_fuse_decode.sv ====
`timescale 1ns/100ps
module css_fuse_decode (
    input wire logic [3:0] src_fuses,
    input wire logic [1:0] sut_fuses,
    input wire logic amp_opt,
    output css_pkg::css_src_t src,
    output logic [1:0] range,
    output css_pkg::css_wcnt_t wcnt,
    output css_pkg::css_dly_t dly,
    output logic reserved
);

    // ----------------------------------------
    // source class and range
    // ----------------------------------------
    always_comb begin
        range = css_pkg::RNG_LOW;
        if (src_fuses >= css_pkg::FUSE_XTAL_MIN) begin
            src = css_pkg::SRC_XTAL;
        end else if (src_fuses == css_pkg::FUSE_LFXTAL) begin
            src = css_pkg::SRC_LFXTAL;
        end else if (src_fuses >= css_pkg::FUSE_EXTRC_MIN) begin
            src = css_pkg::SRC_EXTRC;
        end else if (src_fuses >= css_pkg::FUSE_INTRC_MIN) begin
            src = css_pkg::SRC_INTRC;
        end else begin
            src = css_pkg::SRC_EXTCLK;
        end
        // programmed reads as zero
        if (amp_opt == css_pkg::FUSE_PROGRAMMED) begin
            range = css_pkg::RNG_WIDE;
        end else if (src_fuses[3:1] == css_pkg::XTAL_RNG_MID) begin
            range = css_pkg::RNG_MID;
        end else if (src_fuses[3:1] == css_pkg::XTAL_RNG_HIGH) begin
            range = css_pkg::RNG_HIGH;
        end
    end

    // ----------------------------------------
    // wake count and reset delay
    // ----------------------------------------
    always_comb begin
        wcnt = css_pkg::WC_6;
        dly = css_pkg::css_dly_t'(sut_fuses);
        reserved = 1'b0;
        case (src)
            css_pkg::SRC_XTAL: begin
                case ({src_fuses[0], sut_fuses})
                    3'h0: begin wcnt = css_pkg::WC_258; dly = css_pkg::DL_SHORT; end
                    3'h1: begin wcnt = css_pkg::WC_258; dly = css_pkg::DL_LONG; end
                    3'h2: begin wcnt = css_pkg::WC_1K; dly = css_pkg::DL_NONE; end
                    3'h3: begin wcnt = css_pkg::WC_1K; dly = css_pkg::DL_SHORT; end
                    3'h4: begin wcnt = css_pkg::WC_1K; dly = css_pkg::DL_LONG; end
                    3'h5: begin wcnt = css_pkg::WC_16K; dly = css_pkg::DL_NONE; end
                    3'h6: begin wcnt = css_pkg::WC_16K; dly = css_pkg::DL_SHORT; end
                    default: begin wcnt = css_pkg::WC_16K; dly = css_pkg::DL_LONG; end
                endcase
            end
            css_pkg::SRC_LFXTAL: begin
                wcnt = (sut_fuses[1]) ? css_pkg::WC_32K : css_pkg::WC_1K;
                dly = (sut_fuses == 2'h0) ? css_pkg::DL_SHORT : css_pkg::DL_LONG;
                reserved = (sut_fuses == css_pkg::SUT_RESERVED);
            end
            css_pkg::SRC_EXTRC: begin
                wcnt = (sut_fuses == css_pkg::SUT_RESERVED) ? css_pkg::WC_6 : css_pkg::WC_18;
                dly = (sut_fuses == css_pkg::SUT_RESERVED) ? css_pkg::DL_SHORT : css_pkg::css_dly_t'(sut_fuses);
            end
            default: begin
                // reserved code falls back to the long delay
                if (sut_fuses == css_pkg::SUT_RESERVED) begin
                    dly = css_pkg::DL_LONG;
                    reserved = 1'b1;
                end
            end
        endcase
    end

endmodule : css_fuse_decode

// ==== core/css_tick_counter.sv ====
`timescale 1ns/100ps
module css_tick_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [css_pkg::CNT_W-1:0] load_val,
    input wire logic tick,
    output logic done
);

    // ----------------------------------------
    // down counter of timing ticks
    // ----------------------------------------
    logic [css_pkg::CNT_W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= load_val;
            end else if (tick && cnt_q != '0) begin
                cnt_q <= cnt_q - css_pkg::CNT_ONE;
            end
        end
    end

    // one pulse as the last tick lands
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else if (ce) begin
            done <= !load && tick && cnt_q == css_pkg::CNT_ONE;
        end
    end

endmodule : css_tick_counter

// ==== core/css_clock_ctrl.sv ====
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// - sleep mode stops unused domain clocks
// - core clock stopped holds core logic idle
// - external interrupts clockless while I/O stopped
// - two-wire address match runs without I/O clock
// - program-memory clock follows core clock
// - async timer needs main clock over 4x
// - async timer only with internal oscillator
// - converter clock runs while core stopped in idle and noise modes
// - decode crystal, low-freq crystal, external RC
// - decode internal RC and external clock
// - fuse bit programmed reads zero
// - deep-sleep wake counts source clock cycles
// - reset waits 4096 or 65536 watchdog cycles
// - fuses reset to shipped 0001 and 10
// - crystal range from upper three fuse bits
// - crystal wake count 258, 1K or 16K
// - crystal reset delay none, short or long
// - low-freq crystal wake 1K or 32K
module css_clock_ctrl #(
    parameter logic [16:0] WAKE_16K = 17'h0_4000,
    parameter logic [16:0] WAKE_32K = 17'h0_8000,
    parameter logic [16:0] DLY_LONG = 17'h1_0000
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SRC_TICK,
    input wire logic WDT_TICK,
    input wire logic WAKE,
    output logic CORE_CLK_EN,
    output logic IO_CLK_EN,
    output logic PMEM_CLK_EN,
    output logic ASY_CLK_EN,
    output logic CONV_CLK_EN,
    output logic CORE_HOLD,
    output logic EXT_INT_ASYNC_EN,
    output logic TWI_ADDR_ASYNC_EN
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam bit ASY_RATE_OK = css_pkg::MCLK_HZ > css_pkg::ASY_RATIO * css_pkg::ASY_HZ;

    logic [3:0] src_fuse_q;
    logic [1:0] sut_fuse_q;
    logic amp_q;
    css_pkg::css_mode_t mode_q;
    logic asy_req_q;
    logic wr_q;
    logic [7:0] addr_q;
    css_pkg::css_state_t state_q;
    css_pkg::css_state_t state_d;
    css_pkg::css_src_t dec_src;
    logic [1:0] dec_range;
    css_pkg::css_wcnt_t dec_wcnt;
    css_pkg::css_dly_t dec_dly;
    logic dec_rsvd;
    logic ld;
    logic [css_pkg::CNT_W-1:0] ld_val;
    logic [css_pkg::CNT_W-1:0] wake_val;
    logic cnt_tick;
    logic cnt_done;
    logic addr_ph;
    logic wr_data;
    logic go;
    css_pkg::css_mode_t go_mode;
    logic deep;
    logic core_d;
    logic io_d;
    logic conv_d;
    logic asy_d;
    logic [31:0] rd_d;

    // ----------------------------------------
    // fuse decode and timing counter
    // ----------------------------------------
    css_fuse_decode u_dec (
        .src_fuses(src_fuse_q),
        .sut_fuses(sut_fuse_q),
        .amp_opt(amp_q),
        .src(dec_src),
        .range(dec_range),
        .wcnt(dec_wcnt),
        .dly(dec_dly),
        .reserved(dec_rsvd)
    );

    css_tick_counter u_cnt (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .load(ld),
        .load_val(ld_val),
        .tick(cnt_tick),
        .done(cnt_done)
    );

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign addr_ph = HSEL && HREADY && HTRANS == css_pkg::HTRANS_NONSEQ;
    assign wr_data = wr_q;
    assign go_mode = css_pkg::css_mode_t'(HWDATA[css_pkg::SLP_MODE_LSB +: 3]);
    assign go = wr_data && addr_q == css_pkg::REG_SLEEP && HWDATA[css_pkg::SLP_GO_BIT];

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wr_q <= 1'b0;
            addr_q <= css_pkg::REG_FUSE;
        end else if (CE) begin
            wr_q <= addr_ph && HWRITE;
            if (addr_ph) begin
                addr_q <= HADDR[7:0];
            end
        end
    end

    // zero wait states, never an error
    always_ff @(posedge MCLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= css_pkg::HRESP_OKAY;
        end else if (CE) begin
            HREADYOUT <= 1'b1;
            HRESP <= css_pkg::HRESP_OKAY;
        end
    end

    always_comb begin
        rd_d = '0;
        if (HADDR[7:0] == css_pkg::REG_FUSE) begin
            rd_d[6:0] = {amp_q, sut_fuse_q, src_fuse_q};
        end else if (HADDR[7:0] == css_pkg::REG_SLEEP) begin
            rd_d[3:0] = {asy_req_q, mode_q};
        end else if (HADDR[7:0] == css_pkg::REG_STATUS) begin
            rd_d[19:0] = {asy_req_q && !asy_d, dec_rsvd, CORE_CLK_EN, IO_CLK_EN, PMEM_CLK_EN,
                ASY_CLK_EN, CONV_CLK_EN, state_q, dec_dly, dec_wcnt, dec_range, dec_src};
        end
    end

    // read data sampled in the address phase
    always_ff @(posedge MCLK) begin
        if (RST) begin
            HRDATA <= '0;
        end else if (CE && addr_ph && !HWRITE) begin
            HRDATA <= rd_d;
        end
    end

    // ----------------------------------------
    // fuse and sleep registers
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            src_fuse_q <= css_pkg::SHIP_SRC;
            sut_fuse_q <= css_pkg::SHIP_SUT;
            amp_q <= css_pkg::SHIP_AMP;
        end else if (CE && wr_data && addr_q == css_pkg::REG_FUSE) begin
            src_fuse_q <= HWDATA[css_pkg::FUSE_SRC_LSB +: 4];
            sut_fuse_q <= HWDATA[css_pkg::FUSE_SUT_LSB +: 2];
            amp_q <= HWDATA[css_pkg::FUSE_AMP_BIT];
        end
    end

    // unknown mode codes act as active
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode_q <= css_pkg::MD_ACTIVE;
            asy_req_q <= 1'b0;
        end else if (CE && wr_data && addr_q == css_pkg::REG_SLEEP) begin
            mode_q <= (go_mode > css_pkg::MD_STANDBY) ? css_pkg::MD_ACTIVE : go_mode;
            asy_req_q <= HWDATA[css_pkg::SLP_ASY_BIT];
        end
    end

    // ----------------------------------------
    // start-up sequencer
    // ----------------------------------------
    assign deep = mode_q == css_pkg::MD_PWRDN || mode_q == css_pkg::MD_PWRSAVE;
    assign cnt_tick = (state_q == css_pkg::ST_DELAY) ? WDT_TICK : SRC_TICK;

    always_comb begin
        case (dec_wcnt)
            css_pkg::WC_18: wake_val = css_pkg::CNT_18;
            css_pkg::WC_258: wake_val = css_pkg::CNT_258;
            css_pkg::WC_1K: wake_val = css_pkg::CNT_1K;
            css_pkg::WC_16K: wake_val = WAKE_16K;
            css_pkg::WC_32K: wake_val = WAKE_32K;
            default: wake_val = css_pkg::CNT_6;
        endcase
    end

    always_comb begin
        state_d = state_q;
        ld = 1'b0;
        ld_val = wake_val;
        case (state_q)
            css_pkg::ST_BOOT: begin
                ld = 1'b1;
                if (dec_dly == css_pkg::DL_NONE) begin
                    state_d = css_pkg::ST_START;
                end else begin
                    ld_val = (dec_dly == css_pkg::DL_LONG) ? DLY_LONG : css_pkg::DLY_SHORT;
                    state_d = css_pkg::ST_DELAY;
                end
            end
            css_pkg::ST_DELAY: begin
                if (cnt_done) begin
                    ld = 1'b1;
                    state_d = css_pkg::ST_START;
                end
            end
            css_pkg::ST_START: begin
                if (cnt_done) begin
                    state_d = css_pkg::ST_RUN;
                end
            end
            css_pkg::ST_RUN: begin
                if (go && go_mode != css_pkg::MD_ACTIVE && go_mode <= css_pkg::MD_STANDBY) begin
                    state_d = css_pkg::ST_SLEEP;
                end
            end
            default: begin
                // only the deepest states let the oscillator stop
                if (WAKE && deep) begin
                    ld = 1'b1;
                    state_d = css_pkg::ST_START;
                end else if (WAKE) begin
                    state_d = css_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= css_pkg::ST_BOOT;
        end else if (CE) begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // clock gating
    // ----------------------------------------
    always_comb begin
        core_d = state_q == css_pkg::ST_RUN;
        io_d = core_d || (state_q == css_pkg::ST_SLEEP && mode_q == css_pkg::MD_IDLE);
        conv_d = io_d || (state_q == css_pkg::ST_SLEEP && mode_q == css_pkg::MD_NOISE);
        // crystal pins are only free on the internal oscillator
        asy_d = asy_req_q && ASY_RATE_OK && dec_src == css_pkg::SRC_INTRC;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            CORE_CLK_EN <= 1'b0;
            IO_CLK_EN <= 1'b0;
            PMEM_CLK_EN <= 1'b0;
            ASY_CLK_EN <= 1'b0;
            CONV_CLK_EN <= 1'b0;
            CORE_HOLD <= 1'b1;
            EXT_INT_ASYNC_EN <= 1'b1;
            TWI_ADDR_ASYNC_EN <= 1'b1;
        end else if (CE) begin
            CORE_CLK_EN <= core_d;
            PMEM_CLK_EN <= core_d;
            IO_CLK_EN <= io_d;
            CONV_CLK_EN <= conv_d;
            ASY_CLK_EN <= asy_d;
            CORE_HOLD <= !core_d;
            EXT_INT_ASYNC_EN <= !io_d;
            TWI_ADDR_ASYNC_EN <= !io_d;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST || !CE);

    property p_pmem_core;
        PMEM_CLK_EN == CORE_CLK_EN;
    endproperty
    a_pmem_core: assert property (p_pmem_core) else $error("pmem clock not with core");

    property p_hold;
        CORE_HOLD != CORE_CLK_EN;
    endproperty
    a_hold: assert property (p_hold) else $error("core hold wrong");

    property p_extint;
        EXT_INT_ASYNC_EN == !IO_CLK_EN;
    endproperty
    a_extint: assert property (p_extint) else $error("ext int async wrong");

    property p_twi;
        TWI_ADDR_ASYNC_EN == !IO_CLK_EN;
    endproperty
    a_twi: assert property (p_twi) else $error("twi async wrong");

    property p_asy;
        ASY_CLK_EN |-> $past(dec_src) == css_pkg::SRC_INTRC && $past(asy_req_q);
    endproperty
    a_asy: assert property (p_asy) else $error("async timer on wrong source");

    property p_release;
        state_q == css_pkg::ST_START && cnt_done |=> state_q == css_pkg::ST_RUN ##1
            (CORE_CLK_EN && IO_CLK_EN && PMEM_CLK_EN);
    endproperty
    a_release: assert property (p_release) else $error("clocks not released");

    property p_gated;
        state_q inside {css_pkg::ST_BOOT, css_pkg::ST_DELAY, css_pkg::ST_START} |=>
            !CORE_CLK_EN && !IO_CLK_EN;
    endproperty
    a_gated: assert property (p_gated) else $error("clock open during count");

    property p_wake_deep;
        state_q == css_pkg::ST_SLEEP && WAKE && deep |=> state_q == css_pkg::ST_START [*2];
    endproperty
    a_wake_deep: assert property (p_wake_deep) else $error("deep wake skipped count");

    property p_noise;
        state_q == css_pkg::ST_SLEEP && mode_q == css_pkg::MD_NOISE |=> CONV_CLK_EN && !CORE_CLK_EN;
    endproperty
    a_noise: assert property (p_noise) else $error("converter clock stopped");

    property p_pwrdn;
        state_q == css_pkg::ST_SLEEP && mode_q == css_pkg::MD_PWRDN |=> !IO_CLK_EN && !CONV_CLK_EN;
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("clock runs in power-down");

    property p_ship;
        $fell(RST) |-> src_fuse_q == css_pkg::SHIP_SRC && sut_fuse_q == css_pkg::SHIP_SUT;
    endproperty
    a_ship: assert property (p_ship) else $error("fuses not shipped value");

    property p_long_dly;
        state_q == css_pkg::ST_BOOT && dec_dly == css_pkg::DL_LONG |-> ld && ld_val == DLY_LONG;
    endproperty
    a_long_dly: assert property (p_long_dly) else $error("long reset delay wrong");

    c_run: cover property (state_q == css_pkg::ST_START ##1 state_q == css_pkg::ST_RUN);
    c_deep_wake: cover property (state_q == css_pkg::ST_SLEEP && WAKE && deep);
    c_asy: cover property (ASY_CLK_EN && !CORE_CLK_EN);

endmodule : css_clock_ctrl

// ==== tb/css_osc_model.sv ====
`timescale 1ns/100ps
module css_osc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] div,
    output logic tick
);
    // ----------------------------------------
    // source cycle pulses
    // ----------------------------------------
    logic [3:0] cnt_q;
    // stable resonator-class source, so short start-ups stay safe
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 4'h0;
            tick <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= 4'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick <= 1'b0;
        end
    end
endmodule : css_osc_model

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic wake = 1'b0;
    logic [3:0] src_div = 4'h2;
    logic ce = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [3:0] wdt_div = 4'h1;
    logic [31:0] hrdata, got, rd_d, e_m, m_m;
    logic hreadyout, hresp, src_tick, wdt_tick, core_en, io_en, pmem_en, asy_en, conv_en, hold, ext_en, twi_en;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] rnd = 32'h0000_0027;
    int got_n = 0, seen_n = 0, n_errors = 0, n_tests = 0, ns, nw, nc;
    wire logic [6:0] en_v = {core_en, io_en, pmem_en, conv_en, hold, ext_en, twi_en};
    always #10 mclk = ~mclk;
    css_clock_ctrl #(.WAKE_16K(17'h0_0014), .WAKE_32K(17'h0_0018), .DLY_LONG(17'h0_0028)) u_dut (
        .MCLK(mclk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .SRC_TICK(src_tick), .WDT_TICK(wdt_tick), .WAKE(wake), .CORE_CLK_EN(core_en),
        .IO_CLK_EN(io_en), .PMEM_CLK_EN(pmem_en), .ASY_CLK_EN(asy_en), .CONV_CLK_EN(conv_en),
        .CORE_HOLD(hold), .EXT_INT_ASYNC_EN(ext_en), .TWI_ADDR_ASYNC_EN(twi_en));
    css_osc_model u_src (.clk(mclk), .rst(rst), .div(src_div), .tick(src_tick));
    css_osc_model u_wdt (.clk(mclk), .rst(rst), .div(wdt_div), .tick(wdt_tick));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // expected {delay, wake code, range, class}
    function automatic logic [31:0] dec(input logic [3:0] s, input logic [1:0] u, input logic a);
        logic [2:0] k, c, w;
        logic [1:0] r, d;
        k = {s[0], u};
        r = 2'h0;
        if (s >= 4'hA) begin
            c = 3'h0;
            r = (a == 1'b0) ? 2'h3 : (s[3:1] == 3'h5) ? 2'h0 : (s[3:1] == 3'h6) ? 2'h1 : 2'h2;
            w = (k <= 3'h1) ? 3'h2 : (k <= 3'h4) ? 3'h3 : 3'h4;
            d = (k == 3'h2 || k == 3'h5) ? 2'h0 : (k == 3'h0 || k == 3'h3 || k == 3'h6) ? 2'h1 : 2'h2;
        end else if (s == 4'h9) begin
            c = 3'h1;
            w = u[1] ? 3'h5 : 3'h3;
            d = (u == 2'h0) ? 2'h1 : 2'h2;
        end else if (s >= 4'h5) begin
            c = 3'h2;
            w = (u == 2'h3) ? 3'h0 : 3'h1;
            d = (u == 2'h0) ? 2'h0 : (u == 2'h2) ? 2'h2 : 2'h1;
        end else begin
            c = (s == 4'h0) ? 3'h4 : 3'h3;
            w = 3'h0;
            d = (u == 2'h0) ? 2'h0 : (u == 2'h1) ? 2'h1 : 2'h2;
        end
        return {22'h00_0000, d, w, r, c};
    endfunction : dec
    task settle;
        @(posedge mclk);
        #1;
    endtask : settle
    task chk(input logic [31:0] e, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back(e);
        msk_q.push_back(m);
        got <= v;
        got_n <= got_n + 1;
        @(posedge mclk);
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= css_pkg::HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd_d = hrdata;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0000_0000);
        chk(e, m, rd_d);
    endtask : rd
    task wait_run;
        ns = 0;
        nw = 0;
        nc = 0;
        // count each tick as the counter will sample it at the next edge
        #1;
        while (core_en !== 1'b1 && nc < 3000) begin
            if (src_tick === 1'b1) ns++;
            if (wdt_tick === 1'b1) nw++;
            settle;
            nc++;
        end
    endtask : wait_run
    task stop_test;
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    always @(posedge mclk) begin
        if (got_n != seen_n) begin
            seen_n = got_n;
            e_m = exp_q.pop_front();
            m_m = msk_q.pop_front();
            n_tests++;
            if ((got & m_m) !== (e_m & m_m)) begin
                n_errors++;
                $display("Error t=%0t exp=%h got=%h", $time, e_m, got);
            end
        end
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        stop_test;
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        settle;
        chk(32'h0000_0007, 32'h0000_007F, {25'h000_0000, en_v});
        wait_run;
        chk(32'h0000_0001, 32'h0000_0001, {31'h0000_0000, (nw >= 39 && nw <= 52)});
        settle;
        chk(32'h0000_0078, 32'h0000_007F, {25'h000_0000, en_v});
        rd(8'h00, 32'h0000_0061, 32'h0000_007F);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_0061, 32'h0000_007F);
        for (int i = 0; i < 64; i++) begin
            rnd = xs(rnd);
            bus(1'b1, 8'h00, {25'h000_0000, rnd[0], i[5:0]});
            rd(8'h08, dec(i[3:0], i[5:4], rnd[0]), (i[3:0] >= 4'hA) ? 32'h0000_03FF : 32'h0000_03E7);
        end
        bus(1'b1, 8'h00, 32'h0000_0021);
        bus(1'b1, 8'h04, 32'h0000_0008);
        settle;
        settle;
        chk(32'h0000_0001, 32'h0000_0001, {31'h0000_0000, asy_en});
        bus(1'b1, 8'h00, 32'h0000_007F);
        settle;
        settle;
        chk(32'h0000_0000, 32'h0000_0001, {31'h0000_0000, asy_en});
        rd(8'h08, 32'h0008_0000, 32'h0008_0000);
        bus(1'b1, 8'h00, 32'h0000_0021);
        bus(1'b1, 8'h04, 32'h0000_0000);
        for (int m = 1; m <= 5; m++) begin
            bus(1'b1, 8'h04, 32'h0000_0010 | m);
            settle;
            settle;
            chk({25'h000_0000, (m == 1) ? 7'h2C : (m == 2) ? 7'h0F : 7'h07}, 32'h0000_007F,
                {25'h000_0000, en_v});
            // wake while frozen must be lost
            ce <= 1'b0;
            wake <= 1'b1;
            repeat (3) @(posedge mclk);
            ce <= 1'b1;
            wake <= 1'b0;
            rd(8'h08, 32'h0000_1000, 32'h0000_1C00);
            rnd = xs(rnd);
            src_div <= 4'h2 + {2'h0, rnd[1:0]};
            wake <= 1'b1;
            @(posedge mclk);
            wake <= 1'b0;
            wait_run;
            if (m == 3 || m == 4) chk(32'h0000_0001, 32'h0000_0001, {31'h0000_0000, (ns == 6)});
            else chk(32'h0000_0001, 32'h0000_0001, {31'h0000_0000, (nc <= 3)});
        end
        settle;
        stop_test;
    end
endmodule : testbench
